// File: core/rpc_map.svh
// register offsets, field limits and timing constants of the reading phase controller
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH
`define OFS_CTRL 6'h00
`define OFS_TMO 6'h04
`define OFS_STATUS 6'h08
`define OFS_IRQ_STAT 6'h0c
`define OFS_IRQ_MASK 6'h10
`define OFS_REF_DATA 6'h14
`define OFS_REF_LEN 6'h18
`define OFS_WSTR_DATA 6'h1c
`define OFS_WSTR_LEN 6'h20
`define ADDR_W 6
`define CTRL_W 19
`define TMO_W 14
`define TMO_MIN_MS 14'h0028
`define TMO_MAX_MS 14'h3a98
`define TMO_RST_MS 14'h03e8
`define CLK_NS 20
`define MS_NS 1000000
`define STR_MAX_CHARS 128
`define CHAR_TOP 8'h7e
`define MAX_IN 4
`define NUM_EV 5
`define EV_OPEN 0
`define EV_CLOSE 1
`define EV_TMO 2
`define EV_MISM 3
`define EV_STORE 4
`define CHAR_LSB 0
`define IDX_LSB 8
`endif

// File: core/rpc_pkg.sv
// types shared by the reading phase controller
package rpc_pkg;
    typedef enum logic [1:0] {
        MODE_SERIAL = 2'b00,
        MODE_ONE = 2'b01,
        MODE_TWO = 2'b10
    } mode_e;
    typedef enum logic [1:0] {
        SHUT_OFF = 2'b00,
        SHUT_TRIG = 2'b01,
        SHUT_ON = 2'b10
    } shutter_e;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_OPEN = 2'b01,
        PH_LINGER = 2'b10
    } phase_e;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_CODE = 2'b01,
        TX_STR = 2'b10
    } tx_e;
    typedef struct packed {
        shutter_e shutter;
        logic wrong_str_tx;
        logic wrong_code_tx;
        logic verify_en;
        logic store_open;
        logic stop_open;
        logic start_open;
        logic [1:0] store_sel;
        logic [1:0] stop_sel;
        logic [1:0] start_sel;
        logic ext_phase;
        logic tmo_from_stop;
        logic tmo_en;
        mode_e mode;
    } ctrl_s;
endpackage : rpc_pkg

// File: core/reading_phase_controller.sv
// reading phase sequencer with timeout, code verifier and laser shutter
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "rpc_map.svh"
module reading_phase_controller
    import rpc_pkg::*;
#(
    parameter int NUM_IN = `MAX_IN,
    parameter int CYC_PER_MS = `MS_NS / `CLK_NS,
    parameter int STR_MAX = `STR_MAX_CHARS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [NUM_IN-1:0] in_raw,
    input wire logic serial_start,
    input wire logic serial_stop,
    input wire logic code_valid,
    input wire logic [7:0] code_char,
    input wire logic code_last,
    input wire logic tx_ready,
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic tx_valid,
    output logic [7:0] tx_char,
    output logic tx_last,
    output logic phase_active,
    output logic laser_on,
    output logic irq
);
    localparam int IDX_W = $clog2(STR_MAX);
    localparam logic [31:0] PRE_LAST = 32'(CYC_PER_MS - 1);
    localparam logic [IDX_W:0] LEN_MAX = (IDX_W + 1)'(STR_MAX);

    // index fields assume a power-of-two string store
    if (NUM_IN < 2 || NUM_IN > `MAX_IN || STR_MAX < 2 || STR_MAX > 256
        || (STR_MAX & (STR_MAX - 1)) != 0 || CYC_PER_MS < 1) begin : g_param_check
        $error("reading_phase_controller: unsupported parameters");
    end

    function automatic logic in_active(input logic [`MAX_IN-1:0] raw, input logic [1:0] sel,
                                       input logic open_lvl);
        return raw[sel] ^ open_lvl;
    endfunction : in_active

    function automatic logic [`TMO_W-1:0] clamp_ms(input logic [31:0] v);
        if (v < 32'(`TMO_MIN_MS)) begin
            return `TMO_MIN_MS;
        end
        if (v > 32'(`TMO_MAX_MS)) begin
            return `TMO_MAX_MS;
        end
        return v[`TMO_W-1:0];
    endfunction : clamp_ms

    ctrl_s ctrl;
    logic [`TMO_W-1:0] tmo_ms;
    logic [`NUM_EV-1:0] irq_stat;
    logic [`NUM_EV-1:0] irq_mask;
    phase_e state;
    phase_e next_state;
    tx_e tx_st;
    tx_e next_tx_st;
    logic start_q;
    logic stop_q;
    logic store_q;
    logic [31:0] pre_cnt;
    logic [`TMO_W-1:0] ms_cnt;
    logic [7:0] ref_mem [2][STR_MAX];
    logic [IDX_W:0] ref_len [2];
    logic ref_sel;
    logic [7:0] code_buf [STR_MAX];
    logic [7:0] wstr [STR_MAX];
    logic [IDX_W:0] wstr_len;
    logic [IDX_W:0] cidx;
    logic [IDX_W:0] code_len;
    logic mism;
    logic armed;
    logic cap_bad;
    logic cap_ok;
    logic [IDX_W:0] cap_len;
    logic [IDX_W:0] tidx;
    logic [IDX_W:0] next_tidx;

    wire logic [`MAX_IN-1:0] raw4 = `MAX_IN'(in_raw);
    wire logic start_act = in_active(raw4, ctrl.start_sel, ctrl.start_open);
    wire logic stop_act = in_active(raw4, ctrl.stop_sel, ctrl.stop_open);
    wire logic store_act = in_active(raw4, ctrl.store_sel, ctrl.store_open);
    wire logic start_rise = start_act & ~start_q;
    wire logic start_fall = ~start_act & start_q;
    wire logic stop_fall = ~stop_act & stop_q;
    wire logic store_fall = ~store_act & store_q;

    wire logic suspend = ctrl.shutter == SHUT_ON;
    wire logic serial_mode = ctrl.mode == MODE_SERIAL;
    wire logic open_go = !suspend && state == PH_IDLE
                         && (serial_mode ? serial_start : start_rise);
    wire logic two_stop = stop_fall && (!ctrl.ext_phase || !start_act);
    wire logic stop_ev = serial_mode ? serial_stop
                       : (ctrl.mode == MODE_ONE ? start_fall : two_stop);
    wire logic tmo_ok = ctrl.tmo_en && ctrl.mode != MODE_TWO;
    wire logic counting = (state == PH_OPEN && tmo_ok && !ctrl.tmo_from_stop)
                          || state == PH_LINGER;
    wire logic expire = counting && pre_cnt == PRE_LAST
                        && ms_cnt == `TMO_W'(tmo_ms - `TMO_W'(1));

    always_comb begin
        next_state = state;
        unique case (state)
            PH_IDLE: begin
                if (open_go) begin
                    next_state = PH_OPEN;
                end
            end
            PH_OPEN: begin
                if (expire) begin
                    next_state = PH_IDLE;
                end else if (stop_ev) begin
                    next_state = (tmo_ok && ctrl.tmo_from_stop) ? PH_LINGER : PH_IDLE;
                end
            end
            PH_LINGER: begin
                if (expire) begin
                    next_state = PH_IDLE;
                end
            end
            default: next_state = PH_IDLE;
        endcase
        if (suspend) begin
            next_state = PH_IDLE;
        end
    end

    wire logic phase_close = state != PH_IDLE && next_state == PH_IDLE;
    wire logic count_restart = open_go || (state == PH_OPEN && next_state == PH_LINGER);

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= PH_IDLE;
            phase_active <= 1'b0;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            store_q <= 1'b0;
        end else begin
            state <= next_state;
            phase_active <= next_state != PH_IDLE;
            start_q <= start_act;
            stop_q <= stop_act;
            store_q <= store_act;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || count_restart || !counting) begin
            pre_cnt <= 32'h0000_0000;
            ms_cnt <= '0;
        end else if (pre_cnt == PRE_LAST) begin
            pre_cnt <= 32'h0000_0000;
            ms_cnt <= ms_cnt + `TMO_W'(1);
        end else begin
            pre_cnt <= pre_cnt + 32'h0000_0001;
        end
    end

    // code reception while a phase is open
    wire logic code_in = code_valid && state != PH_IDLE;
    wire logic code_end = code_in && code_last;
    wire logic [IDX_W-1:0] cpos = cidx[IDX_W-1:0];
    wire logic cfull = cidx == LEN_MAX;
    wire logic [IDX_W:0] code_n = cfull ? cidx : cidx + (IDX_W + 1)'(1);
    wire logic char_diff = cfull || cidx >= ref_len[ref_sel]
                           || code_char != ref_mem[ref_sel][cpos];
    wire logic len_diff = (cidx + (IDX_W + 1)'(1)) != ref_len[ref_sel];
    wire logic mism_go = code_end && ctrl.verify_en && !armed && (mism || char_diff || len_diff);
    wire logic char_bad = code_char > `CHAR_TOP || cfull;
    wire logic commit = armed && store_fall && state == PH_IDLE && cap_ok;
    wire logic buf_hold = tx_st == TX_CODE;

    always_ff @(posedge mclk) begin
        if (rst || code_end) begin
            cidx <= '0;
            mism <= 1'b0;
        end else if (code_in) begin
            cidx <= cfull ? cidx : cidx + (IDX_W + 1)'(1);
            mism <= mism || char_diff;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            code_len <= '0;
        end else if (code_end && !buf_hold) begin
            code_len <= cfull ? cidx : cidx + (IDX_W + 1)'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (code_in && !buf_hold && !cfull) begin
            code_buf[cpos] <= code_char;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || store_fall) begin
            armed <= 1'b0;
            cap_ok <= 1'b0;
            cap_bad <= 1'b0;
            cap_len <= '0;
        end else if (open_go) begin
            armed <= store_act;
            cap_ok <= 1'b0;
            cap_bad <= 1'b0;
        end else if (armed && code_in) begin
            cap_bad <= cap_bad || char_bad;
            if (code_last) begin
                cap_ok <= !(cap_bad || char_bad);
                cap_len <= cidx + (IDX_W + 1)'(1);
            end
        end
    end

    // capture fills the idle bank so a failed capture leaves the old reference
    wire logic reg_ref_wr = reg_wr && reg_addr == `OFS_REF_DATA
                            && reg_wdata[`CHAR_LSB+:8] <= `CHAR_TOP;
    wire logic [IDX_W-1:0] reg_idx = reg_wdata[`IDX_LSB+:IDX_W];
    always_ff @(posedge mclk) begin
        if (reg_ref_wr) begin
            ref_mem[ref_sel][reg_idx] <= reg_wdata[`CHAR_LSB+:8];
        end
        if (armed && code_in && !cfull) begin
            ref_mem[~ref_sel][cpos] <= code_char;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_sel <= 1'b0;
            ref_len[0] <= '0;
            ref_len[1] <= '0;
        end else if (commit) begin
            ref_sel <= ~ref_sel;
            ref_len[~ref_sel] <= cap_len;
        end else if (reg_wr && reg_addr == `OFS_REF_LEN) begin
            ref_len[ref_sel] <= reg_wdata[IDX_W:0] > LEN_MAX ? LEN_MAX : reg_wdata[IDX_W:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reg_wr && reg_addr == `OFS_WSTR_DATA) begin
            wstr[reg_idx] <= reg_wdata[`CHAR_LSB+:8];
        end
    end

    // mismatch transmit order: code then message
    wire logic str_on = ctrl.wrong_str_tx && wstr_len != '0;
    wire tx_e after_code = str_on ? TX_STR : TX_IDLE;
    wire logic [IDX_W:0] tx_end = (tx_st == TX_STR ? wstr_len : code_len) - (IDX_W + 1)'(1);
    always_comb begin
        next_tx_st = tx_st;
        next_tidx = tidx;
        unique case (tx_st)
            TX_IDLE: begin
                if (mism_go) begin
                    next_tx_st = ctrl.wrong_code_tx ? TX_CODE : after_code;
                    next_tidx = '0;
                end
            end
            TX_CODE, TX_STR: begin
                if (tx_ready) begin
                    next_tidx = tidx + (IDX_W + 1)'(1);
                    if (tidx == tx_end) begin
                        next_tx_st = tx_st == TX_CODE ? after_code : TX_IDLE;
                        next_tidx = '0;
                    end
                end
            end
            default: next_tx_st = TX_IDLE;
        endcase
    end

    wire logic [IDX_W-1:0] npos = next_tidx[IDX_W-1:0];
    // a code ending in the start cycle is not yet in code_buf or code_len: forward it
    wire logic [IDX_W:0] len_now = (code_end && !buf_hold) ? code_n : code_len;
    wire logic fwd_char = code_in && !buf_hold && cidx == next_tidx;
    wire logic [IDX_W:0] next_end = (next_tx_st == TX_STR ? wstr_len : len_now)
                                    - (IDX_W + 1)'(1);
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_st <= TX_IDLE;
            tidx <= '0;
            tx_char <= 8'h00;
            tx_last <= 1'b0;
        end else begin
            tx_st <= next_tx_st;
            tidx <= next_tidx;
            tx_char <= next_tx_st == TX_STR ? wstr[npos] : (fwd_char ? code_char : code_buf[npos]);
            tx_last <= next_tx_st != TX_IDLE && next_tidx == next_end;
        end
    end
    assign tx_valid = tx_st != TX_IDLE;

    // laser shutter
    always_ff @(posedge mclk) begin
        if (rst) begin
            laser_on <= 1'b0;
        end else begin
            unique case (ctrl.shutter)
                SHUT_OFF: laser_on <= 1'b1;
                SHUT_TRIG: laser_on <= open_go ? 1'b1
                                     : ((code_end || phase_close) ? 1'b0 : laser_on);
                default: laser_on <= 1'b0;
            endcase
        end
    end

    // register file and interrupt status
    wire logic [`NUM_EV-1:0] ev = {
        commit, mism_go, expire && next_state == PH_IDLE, phase_close, open_go
    };
    wire logic [`NUM_EV-1:0] w1c = (reg_wr && reg_addr == `OFS_IRQ_STAT)
                                   ? reg_wdata[`NUM_EV-1:0] : '0;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= ctrl_s'('0);
            tmo_ms <= `TMO_RST_MS;
            irq_mask <= '0;
            wstr_len <= '0;
            irq_stat <= '0;
        end else begin
            // set wins over a clear in the same cycle
            irq_stat <= (irq_stat & ~w1c) | ev;
            if (reg_wr) begin
                unique case (reg_addr)
                    `OFS_CTRL: ctrl <= ctrl_s'(reg_wdata[`CTRL_W-1:0]);
                    `OFS_TMO: tmo_ms <= clamp_ms(reg_wdata);
                    `OFS_IRQ_MASK: irq_mask <= reg_wdata[`NUM_EV-1:0];
                    `OFS_WSTR_LEN: wstr_len <= reg_wdata[IDX_W:0] > LEN_MAX
                                               ? LEN_MAX : reg_wdata[IDX_W:0];
                    default: ;
                endcase
            end
        end
    end
    assign irq = |(irq_stat & irq_mask);

    wire logic [31:0] status_word = {28'h0000000, tx_valid, armed, laser_on, phase_active};
    wire logic [31:0] rd_mux =
        reg_addr == `OFS_CTRL ? 32'(ctrl) :
        reg_addr == `OFS_TMO ? 32'(tmo_ms) :
        reg_addr == `OFS_STATUS ? status_word :
        reg_addr == `OFS_IRQ_STAT ? 32'(irq_stat) :
        reg_addr == `OFS_IRQ_MASK ? 32'(irq_mask) :
        reg_addr == `OFS_REF_LEN ? 32'(ref_len[ref_sel]) :
        reg_addr == `OFS_WSTR_LEN ? 32'(wstr_len) : 32'h0000_0000;
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_two_open;
        state == PH_OPEN && ctrl.mode == MODE_TWO && !suspend;
    endsequence
    sequence s_capture_done;
        armed && cap_ok && state == PH_IDLE ##1 store_fall;
    endsequence

    chk_blank_suspend: assert property (
        suspend |=> !laser_on && !phase_active) else $error("laser or phase live while blanked");
    chk_blank_off_on: assert property (
        ctrl.shutter == SHUT_OFF |=> laser_on) else $error("laser off with blanking disabled");
    chk_trig_laser: assert property (
        ctrl.shutter == SHUT_TRIG && open_go ##1 ctrl.shutter == SHUT_TRIG && !code_end
        && !phase_close |=> laser_on) else $error("laser not on at phase start");
    chk_two_close: assert property (
        s_two_open and (stop_fall && !ctrl.ext_phase) |=> !phase_active)
        else $error("two-input phase not closed on stop");
    chk_ext_hold: assert property (
        s_two_open and (ctrl.ext_phase && start_act) |=> phase_active)
        else $error("extended phase closed with start active");
    chk_tmo_mode: assert property (
        state == PH_OPEN && ctrl.mode == MODE_TWO |-> !counting)
        else $error("timeout counting in two-input mode");
    chk_tmo_range: assert property (
        tmo_ms >= `TMO_MIN_MS && tmo_ms <= `TMO_MAX_MS) else $error("timeout out of range");
    chk_start_origin: assert property (
        open_go && tmo_ok && !ctrl.tmo_from_stop |=> ms_cnt == '0 && pre_cnt == 32'h0)
        else $error("start origin count not restarted");
    chk_stop_extend: assert property (
        state == PH_OPEN && stop_ev && !expire && tmo_ok && ctrl.tmo_from_stop && !suspend
        |=> state == PH_LINGER && phase_active) else $error("stop origin did not extend");
    chk_tmo_expire: assert property (
        expire && !suspend |=> !phase_active) else $error("phase open after timeout");
    chk_store_commit: assert property (
        s_capture_done |=> ref_sel != $past(ref_sel)) else $error("captured code not stored");
    chk_mism_tx: assert property (
        mism_go && tx_st == TX_IDLE && ctrl.wrong_code_tx |=> tx_valid && tx_st == TX_CODE)
        else $error("wrong code not sent");
endmodule : reading_phase_controller

// File: verification/serial_host.sv
// serial host model that takes transmitted characters, stalling on request
`timescale 1ns/1ps
module serial_host (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    input wire logic tx_last,
    output logic tx_ready,
    output logic [63:0] rx_log,
    output int rx_n,
    output int n_last
);
    // stalling accepts every other cycle, so each character must hold
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_ready <= 1'b0;
            rx_log <= '0;
            rx_n <= 0;
            n_last <= 0;
        end else begin
            tx_ready <= stall ? !tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                rx_log <= {rx_log[55:0], tx_char};
                rx_n <= rx_n + 1;
                n_last <= n_last + int'(tx_last);
            end
        end
    end
endmodule : serial_host

// File: verification/tb.sv
// self-checking bench of the reading phase controller
`timescale 1ns/1ps
`include "rpc_map.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb;
    logic mclk = 0, rst = 1, stall = 1;
    logic [3:0] in_raw = '0;
    logic serial_start = 0, serial_stop = 0, code_valid = 0, code_last = 0;
    logic [7:0] code_char = '0, tx_char;
    logic [5:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, rdv;
    logic reg_wr = 0, reg_rd = 0, tx_ready, tx_valid, tx_last, phase_active, laser_on, irq;
    logic [63:0] rx_log;
    int rx_n, n_last, err_count, n_checks, cyc;

    // ten cycles per millisecond keeps the timeouts short
    reading_phase_controller #(.CYC_PER_MS(10)) dut (.mclk(mclk), .rst(rst), .in_raw(in_raw),
        .serial_start(serial_start), .serial_stop(serial_stop), .code_valid(code_valid),
        .code_char(code_char), .code_last(code_last), .tx_ready(tx_ready),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_char(tx_char), .tx_last(tx_last),
        .phase_active(phase_active), .laser_on(laser_on), .irq(irq));
    serial_host host (.mclk(mclk), .rst(rst), .stall(stall), .tx_valid(tx_valid),
        .tx_char(tx_char), .tx_last(tx_last), .tx_ready(tx_ready), .rx_log(rx_log),
        .rx_n(rx_n), .n_last(n_last));

    always #10 mclk = ~mclk;

    task automatic end_of_test;
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : ticks

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [5:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask : rd

    task automatic pulse(input bit stop);
        @(posedge mclk);
        serial_start <= !stop;
        serial_stop <= stop;
        @(posedge mclk);
        serial_start <= 1'b0;
        serial_stop <= 1'b0;
        #1;
    endtask : pulse

    task automatic set_in(input int i, input logic v);
        @(posedge mclk);
        in_raw[i] <= v;
        ticks(2);
        #1;
    endtask : set_in

    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge mclk);
            code_valid <= 1'b1;
            code_char <= s[i];
            code_last <= (i == s.len() - 1);
        end
        @(posedge mclk);
        code_valid <= 1'b0;
        code_last <= 1'b0;
    endtask : send

    task automatic s_regs;
        rd(`OFS_TMO);
        `CHK("tmo reset", 32'h3e8, rdv)
        wr(`OFS_TMO, 32'h5);
        rd(`OFS_TMO);
        `CHK("tmo low", 32'h28, rdv)
        wr(`OFS_TMO, 32'h4e20);
        rd(`OFS_TMO);
        `CHK("tmo high", 32'h3a98, rdv)
        rd(6'h3c);
        `CHK("unmapped", 32'h0, rdv)
        `CHK("laser idle", 1'b1, laser_on)
    endtask : s_regs

    task automatic s_serial_tmo;
        wr(`OFS_TMO, 32'h28);
        wr(`OFS_CTRL, 32'h4);
        wr(`OFS_IRQ_MASK, 32'h4);
        pulse(0);
        `CHK("serial open", 1'b1, phase_active)
        ticks(385);
        `CHK("before tmo", 1'b1, phase_active)
        ticks(30);
        `CHK("after tmo", 1'b0, phase_active)
        `CHK("tmo irq", 1'b1, irq)
        wr(`OFS_IRQ_MASK, 32'h0);
        `CHK("masked", 1'b0, irq)
        wr(`OFS_IRQ_STAT, 32'h1f);
        wr(`OFS_IRQ_MASK, 32'h4);
        `CHK("cleared", 1'b0, irq)
    endtask : s_serial_tmo

    task automatic s_levels;
        // start active-open; the pin is parked closed before switching level
        wr(`OFS_CTRL, 32'h0);
        set_in(0, 1);
        wr(`OFS_CTRL, 32'h801);
        set_in(0, 0);
        `CHK("open level", 1'b1, phase_active)
        set_in(0, 1);
        `CHK("open close", 1'b0, phase_active)
        wr(`OFS_CTRL, 32'h0);
        set_in(0, 0);
        wr(`OFS_CTRL, 32'hd);
        set_in(0, 1);
        `CHK("closed level", 1'b1, phase_active)
        set_in(0, 0);
        ticks(375);
        `CHK("stop extend", 1'b1, phase_active)
        ticks(35);
        `CHK("stop tmo end", 1'b0, phase_active)
    endtask : s_levels

    task automatic s_two;
        wr(`OFS_CTRL, 32'h136);
        set_in(0, 1);
        `CHK("wrong input", 1'b0, phase_active)
        set_in(1, 1);
        `CHK("two open", 1'b1, phase_active)
        rd(`OFS_STATUS);
        `CHK("status open", 32'h7, rdv)
        set_in(2, 1);
        set_in(2, 0);
        `CHK("ext hold", 1'b1, phase_active)
        ticks(450);
        `CHK("no tmo", 1'b1, phase_active)
        set_in(1, 0);
        set_in(2, 1);
        set_in(2, 0);
        `CHK("two close", 1'b0, phase_active)
        set_in(0, 0);
    endtask : s_two

    task automatic s_verify;
        wr(`OFS_CTRL, 32'h1c000);
        wr(`OFS_REF_DATA, 32'h41);
        wr(`OFS_REF_DATA, 32'h142);
        wr(`OFS_REF_LEN, 32'h2);
        wr(`OFS_WSTR_DATA, 32'h58);
        wr(`OFS_WSTR_LEN, 32'h1);
        wr(`OFS_REF_DATA, 32'h7f);
        wr(`OFS_IRQ_MASK, 32'h8);
        pulse(0);
        send("AB");
        ticks(20);
        `CHK("match quiet", 0, rx_n)
        send("AC");
        ticks(40);
        `CHK("tx count", 3, rx_n)
        `CHK("tx chars", 24'h414358, rx_log[23:0])
        `CHK("item ends", 2, n_last)
        `CHK("mism irq", 1'b1, irq)
        pulse(1);
        wr(`OFS_IRQ_STAT, 32'h1f);
    endtask : s_verify

    task automatic s_capture;
        wr(`OFS_CTRL, 32'h1c600);
        set_in(3, 1);
        pulse(0);
        send("Z");
        pulse(1);
        set_in(3, 0);
        ticks(4);
        rd(`OFS_IRQ_STAT);
        `CHK("stored", 1'b1, rdv[4])
        pulse(0);
        send("Z");
        ticks(20);
        `CHK("new ref", 3, rx_n)
        send("Q");
        ticks(20);
        `CHK("short count", 5, rx_n)
        `CHK("short wrong", 16'h5158, rx_log[15:0])
        `CHK("short ends", 4, n_last)
        pulse(1);
    endtask : s_capture

    task automatic s_shutter;
        wr(`OFS_CTRL, 32'h20000);
        pulse(0);
        `CHK("trig on", 1'b1, laser_on)
        send("A");
        ticks(2);
        `CHK("trig off", 1'b0, laser_on)
        pulse(1);
        `CHK("trig idle", 1'b0, laser_on)
        pulse(0);
        `CHK("trig again", 1'b1, laser_on)
        pulse(1);
        `CHK("trig end", 1'b0, laser_on)
        wr(`OFS_CTRL, 32'h40000);
        pulse(0);
        `CHK("shut laser", 1'b0, laser_on)
        `CHK("shut idle", 1'b0, phase_active)
    endtask : s_shutter

    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        ticks(2);
        s_regs();
        s_serial_tmo();
        s_levels();
        s_two();
        s_verify();
        s_capture();
        s_shutter();
        end_of_test();
    end

    // the whole run needs about 1550 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            end_of_test();
        end
    end
endmodule : tb
